// ---- evu_defines.svh ----
// Constants of the exception vectoring unit
`ifndef EVU_DEFINES_SVH
`define EVU_DEFINES_SVH
`define EVU_VEC_BREAKPOINT 8'h03
`define EVU_VEC_OVERFLOW 8'h04
`define EVU_VEC_RANGE 8'h05
`define EVU_VEC_FP_ERROR 8'h10
`define EVU_VEC_SIMD_FP 8'h13
`define EVU_FLAG_OVERFLOW 11
`define EVU_FLAG_INT_ENABLE 9
`define EVU_NULL_SELECTOR 16'h0000
`define EVU_RM_ENTRY_BYTES 64'h0000000000000004
`define EVU_PUSH_BYTES_64 64'h0000000000000008
`define EVU_PUSH_BYTES_LEG 64'h0000000000000004
`define EVU_RM_PUSH_BYTES 64'h0000000000000002
`define EVU_FP_COND_COUNT 6
`endif

// ---- evu_pkg.sv ----
// Types of the exception vectoring unit
`default_nettype none
package evu_pkg;
  typedef enum logic [2:0] {
    EVU_MODE_REAL = 3'h1,
    EVU_MODE_PROT = 3'h2,
    EVU_MODE_LONG = 3'h4
  } evu_mode_t;
  typedef enum logic [3:0] {
    EVU_INS_NONE = 4'h0,
    EVU_INS_SOFT_INT = 4'h1,
    EVU_INS_OVF_TRAP = 4'h2,
    EVU_INS_BREAK = 4'h3,
    EVU_INS_RANGE = 4'h4,
    EVU_INS_INTERRUPT_RETURN_INSTRUCTION = 4'h5,
    EVU_INS_FPU = 4'h6,
    EVU_INS_SIMD = 4'h7
  } evu_ins_t;
  typedef enum logic [1:0] {
    EVU_GATE_INTR = 2'h0,
    EVU_GATE_TRAP = 2'h1,
    EVU_GATE_TASK = 2'h2
  } evu_gate_t;
  typedef struct packed {
    logic [31:0] flags;
    logic [63:0] ip;
    logic [15:0] cs;
    logic [15:0] ss;
    logic [63:0] sp;
    logic [1:0] current_privilege_level;
  } evu_state_t;
  typedef struct packed {
    evu_ins_t kind;
    logic [7:0] vector;
    logic [31:0] operand;
    logic [31:0] lower;
    logic [31:0] upper;
    logic [5:0] fp_cond;
    logic has_error;
    logic [31:0] error_code;
  } evu_req_t;
  typedef struct packed {
    evu_gate_t gate;
    logic [1:0] dpl;
    logic [15:0] cs;
    logic [63:0] ip;
    logic smm;
  } evu_gate_desc_t;
  typedef struct packed {
    logic [63:0] value;
    logic [63:0] bytes;
  } evu_push_t;
endpackage
`default_nettype wire

// ---- evu_core.sv ----
// Exception vectoring unit: dispatch, state push, task call and return
`timescale 1ns/1ns
`default_nettype none
`include "evu_defines.svh"

module evu_core
  import evu_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic req_valid_i,
  input wire evu_req_t req_i,
  input wire evu_mode_t mode_i,
  input wire evu_state_t cur_state_i,
  input wire evu_gate_desc_t gate_i,
  input wire logic [63:0] rm_table_entry_i,
  output logic busy_o,
  output logic [7:0] table_index_o,
  output logic table_index_valid_o,
  output logic push_valid_o,
  output evu_push_t push_o,
  output logic redirect_valid_o,
  output evu_state_t redirect_state_o,
  output logic code64_o,
  output logic task_save_o,
  output evu_state_t task_saved_o,
  output logic [7:0] vector_o,
  output logic vector_valid_o
);

  // ************************************************************
  // Sequencer
  // ************************************************************
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_LOOKUP = 5'h02,
    ST_PUSH = 5'h04,
    ST_ENTER = 5'h08,
    ST_RETURN = 5'h10
  } evu_seq_t;

  function automatic logic [63:0] zext16(input logic [15:0] v);
    zext16 = {48'h000000000000, v};
  endfunction

  function automatic logic [63:0] zext32(input logic [31:0] v);
    zext32 = {32'h00000000, v};
  endfunction

  evu_seq_t state_ff;
  logic [7:0] vec_ff;
  logic [2:0] push_idx_ff;
  logic [2:0] push_last_ff;
  logic has_err_ff;
  logic [31:0] err_ff;
  evu_state_t saved_ff;
  evu_state_t task_saved_ff;
  logic task_active_ff;
  evu_mode_t mode_ff;
  logic [63:0] rm_target_ff;

  logic take_vec;
  logic [7:0] take_num;
  logic out_of_range;
  logic fp_any;

  // ************************************************************
  // Instruction decode
  // ************************************************************

  assign out_of_range = ($signed(req_i.operand) < $signed(req_i.lower)) ||
                        ($signed(req_i.operand) > $signed(req_i.upper));
  assign fp_any = |req_i.fp_cond;

  // Decode which instruction raises which vector
  always_comb begin
    take_vec = 1'b0;
    take_num = 8'h00;
    case (req_i.kind)
      EVU_INS_SOFT_INT: begin
        take_vec = 1'b1;
        take_num = req_i.vector;
      end
      EVU_INS_OVF_TRAP: begin
        take_vec = cur_state_i.flags[`EVU_FLAG_OVERFLOW];
        take_num = `EVU_VEC_OVERFLOW;
      end
      EVU_INS_BREAK: begin
        take_vec = 1'b1;
        take_num = `EVU_VEC_BREAKPOINT;
      end
      EVU_INS_RANGE: begin
        take_vec = out_of_range;
        take_num = `EVU_VEC_RANGE;
      end
      EVU_INS_FPU: begin
        take_vec = fp_any;
        take_num = `EVU_VEC_FP_ERROR;
      end
      EVU_INS_SIMD: begin
        take_vec = fp_any;
        take_num = `EVU_VEC_SIMD_FP;
      end
      default: begin
        take_vec = 1'b0;
        take_num = 8'h00;
      end
    endcase
  end

  logic start;
  logic start_ret;
  assign start = (state_ff == ST_IDLE) && req_valid_i && take_vec;
  assign start_ret = (state_ff == ST_IDLE) && req_valid_i && (req_i.kind == EVU_INS_INTERRUPT_RETURN_INSTRUCTION);

  // Privilege change decides the optional stack push in protected mode
  logic cpl_change;
  assign cpl_change = (gate_i.dpl != saved_ff.current_privilege_level);

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      state_ff <= ST_IDLE;
      vec_ff <= 8'h00;
      has_err_ff <= 1'b0;
      err_ff <= 32'h00000000;
      saved_ff <= '0;
      mode_ff <= EVU_MODE_REAL;
      push_idx_ff <= 3'h0;
      push_last_ff <= 3'h0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (start) begin
            vec_ff <= take_num;
            has_err_ff <= req_i.has_error;
            err_ff <= req_i.error_code;
            saved_ff <= cur_state_i;
            mode_ff <= mode_i;
            state_ff <= ST_LOOKUP;
          end else if (start_ret) begin
            state_ff <= ST_RETURN;
          end
        end
        ST_LOOKUP: begin
          push_idx_ff <= 3'h0;
          if (mode_ff == EVU_MODE_REAL) begin
            push_last_ff <= has_err_ff ? 3'h3 : 3'h2;
            state_ff <= ST_PUSH;
          end else if (gate_i.gate == EVU_GATE_TASK) begin
            state_ff <= ST_ENTER;
          end else begin
            // Order: ss, sp, flags, cs, ip, error; skip stack pair when not needed
            push_idx_ff <= ((mode_ff == EVU_MODE_LONG) || cpl_change) ? 3'h0 : 3'h2;
            push_last_ff <= has_err_ff ? 3'h5 : 3'h4;
            state_ff <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          push_idx_ff <= push_idx_ff + 3'h1;
          if (push_idx_ff == push_last_ff) begin
            state_ff <= ST_ENTER;
          end
        end
        ST_ENTER: begin
          state_ff <= ST_IDLE;
        end
        ST_RETURN: begin
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Real-mode table lookup
  // ************************************************************
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      table_index_o <= 8'h00;
      table_index_valid_o <= 1'b0;
      rm_target_ff <= 64'h0000000000000000;
    end else begin
      table_index_valid_o <= start && (mode_i == EVU_MODE_REAL);
      if (start) begin
        table_index_o <= take_num;
      end
      if (state_ff == ST_LOOKUP && mode_ff == EVU_MODE_REAL) begin
        rm_target_ff <= rm_table_entry_i;
      end
    end
  end

  // ************************************************************
  // Stack pushes
  // ************************************************************
  logic [63:0] push_val;
  always_comb begin
    push_val = 64'h0000000000000000;
    if (mode_ff == EVU_MODE_REAL) begin
      case (push_idx_ff)
        3'h0: push_val = zext32(saved_ff.flags);
        3'h1: push_val = zext16(saved_ff.cs);
        3'h2: push_val = saved_ff.ip;
        3'h3: push_val = zext32(err_ff);
        default: push_val = 64'h0000000000000000;
      endcase
    end else begin
      case (push_idx_ff)
        3'h0: push_val = zext16(saved_ff.ss);
        3'h1: push_val = saved_ff.sp;
        3'h2: push_val = zext32(saved_ff.flags);
        3'h3: push_val = zext16(saved_ff.cs);
        3'h4: push_val = saved_ff.ip;
        3'h5: push_val = zext32(err_ff);
        default: push_val = 64'h0000000000000000;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      push_valid_o <= 1'b0;
      push_o <= '0;
    end else begin
      push_valid_o <= (state_ff == ST_PUSH);
      push_o.value <= push_val;
      if (mode_ff == EVU_MODE_LONG) begin
        push_o.bytes <= `EVU_PUSH_BYTES_64;
      end else if (mode_ff == EVU_MODE_REAL) begin
        push_o.bytes <= `EVU_RM_PUSH_BYTES;
      end else begin
        push_o.bytes <= `EVU_PUSH_BYTES_LEG;
      end
    end
  end

  // ************************************************************
  // Handler entry, task call and return
  // ************************************************************
  evu_state_t entry_state;
  always_comb begin
    entry_state = saved_ff;
    if (mode_ff == EVU_MODE_REAL) begin
      entry_state.cs = rm_target_ff[31:16];
      entry_state.ip = zext16(rm_target_ff[15:0]);
    end else begin
      entry_state.cs = gate_i.cs;
      entry_state.ip = gate_i.ip;
      entry_state.current_privilege_level = gate_i.dpl;
      if (mode_ff == EVU_MODE_LONG && cpl_change) begin
        entry_state.ss = `EVU_NULL_SELECTOR;
      end
    end
    if (gate_i.gate == EVU_GATE_INTR || mode_ff == EVU_MODE_REAL) begin
      entry_state.flags[`EVU_FLAG_INT_ENABLE] = 1'b0;
    end
  end

  // Task call keeps the interrupted image but jumps into the handler task
  evu_state_t task_entry_state;
  always_comb begin
    task_entry_state = saved_ff;
    task_entry_state.cs = gate_i.cs;
    task_entry_state.ip = gate_i.ip;
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      redirect_valid_o <= 1'b0;
      redirect_state_o <= '0;
      code64_o <= 1'b0;
      task_save_o <= 1'b0;
      task_saved_o <= '0;
      task_saved_ff <= '0;
      task_active_ff <= 1'b0;
      vector_o <= 8'h00;
      vector_valid_o <= 1'b0;
    end else begin
      redirect_valid_o <= 1'b0;
      task_save_o <= 1'b0;
      vector_valid_o <= start;
      if (start) begin
        vector_o <= take_num;
      end
      if (state_ff == ST_ENTER) begin
        redirect_valid_o <= 1'b1;
        if (mode_ff != EVU_MODE_REAL && gate_i.gate == EVU_GATE_TASK) begin
          task_saved_ff <= saved_ff;
          task_saved_o <= saved_ff;
          task_save_o <= 1'b1;
          task_active_ff <= 1'b1;
          redirect_state_o <= task_entry_state;
        end else begin
          redirect_state_o <= entry_state;
        end
        code64_o <= (mode_ff == EVU_MODE_LONG) && !gate_i.smm;
      end else if (state_ff == ST_RETURN) begin
        redirect_valid_o <= 1'b1;
        if (task_active_ff) begin
          redirect_state_o <= task_saved_ff;
          task_active_ff <= 1'b0;
        end else begin
          redirect_state_o <= saved_ff;
        end
        code64_o <= (mode_ff == EVU_MODE_LONG);
      end
    end
  end

  // ************************************************************
  // Busy flag
  // ************************************************************
  // Drops with the redirect pulse, so the next request may follow at once
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= (start || start_ret) || ((state_ff != ST_IDLE) && (state_ff != ST_ENTER)
                && (state_ff != ST_RETURN));
    end
  end

endmodule // evu_core
`default_nettype wire

// ---- evu_core_sva.sv ----
// Port assertions of the exception vectoring unit
`timescale 1ns/1ns
`default_nettype none
`include "evu_defines.svh"
module evu_core_sva
  import evu_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic req_valid_i,
  input wire evu_req_t req_i,
  input wire evu_mode_t mode_i,
  input wire evu_state_t cur_state_i,
  input wire evu_gate_desc_t gate_i,
  input wire logic busy_o,
  input wire logic [7:0] table_index_o,
  input wire logic table_index_valid_o,
  input wire logic push_valid_o,
  input wire evu_push_t push_o,
  input wire logic redirect_valid_o,
  input wire logic task_save_o,
  input wire evu_state_t task_saved_o,
  input wire logic [7:0] vector_o,
  input wire logic vector_valid_o
);
  wire logic acc_w = req_valid_i && !busy_o;
  wire logic out_w = $signed(req_i.operand) < $signed(req_i.lower) ||
    $signed(req_i.operand) > $signed(req_i.upper);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  AST_INDEX: assert property (table_index_valid_o |-> vector_valid_o && table_index_o == vector_o)
    else $error("table index differs from vector");
  AST_SOFT: assert property (acc_w && req_i.kind == EVU_INS_SOFT_INT |=>
    vector_valid_o && vector_o == $past(req_i.vector)) else $error("soft vector wrong");
  AST_BREAK: assert property (acc_w && req_i.kind == EVU_INS_BREAK |=>
    vector_valid_o && vector_o == `EVU_VEC_BREAKPOINT) else $error("breakpoint missing");
  AST_OVF: assert property (acc_w && req_i.kind == EVU_INS_OVF_TRAP |=>
    vector_valid_o == $past(cur_state_i.flags[11]) && (!vector_valid_o ||
    vector_o == `EVU_VEC_OVERFLOW)) else $error("overflow trap wrong");
  AST_RANGE: assert property (acc_w && req_i.kind == EVU_INS_RANGE |=>
    vector_valid_o == $past(out_w)) else $error("range check wrong");
  AST_FPE: assert property (acc_w && req_i.kind == EVU_INS_FPU && req_i.fp_cond != 6'h00 |=>
    vector_valid_o && vector_o == `EVU_VEC_FP_ERROR) else $error("fp error vector wrong");
  AST_SIMD: assert property (acc_w && req_i.kind == EVU_INS_SIMD && req_i.fp_cond != 6'h00 |=>
    vector_valid_o && vector_o == `EVU_VEC_SIMD_FP) else $error("simd vector wrong");
  AST_REAL: assert property (acc_w && req_i.kind == EVU_INS_SOFT_INT && mode_i == EVU_MODE_REAL |->
    ##3 (push_valid_o && push_o.bytes == `EVU_RM_PUSH_BYTES)[*3]) else $error("real push wrong");
  AST_LONG: assert property (acc_w && req_i.kind == EVU_INS_SIMD && req_i.fp_cond != 6'h00 &&
    mode_i == EVU_MODE_LONG && gate_i.gate != EVU_GATE_TASK |->
    ##3 (push_valid_o && push_o.bytes == `EVU_PUSH_BYTES_64)[*5])
    else $error("long push wrong");
  AST_TASK: assert property (acc_w && req_i.kind == EVU_INS_BREAK && gate_i.gate == EVU_GATE_TASK &&
    mode_i == EVU_MODE_PROT |-> ##3 task_save_o && !push_valid_o &&
    task_saved_o == $past(cur_state_i, 3)) else $error("task save wrong");
  AST_INTERRUPT_RETURN_INSTRUCTION: assert property (acc_w && req_i.kind == EVU_INS_INTERRUPT_RETURN_INSTRUCTION |-> ##2 redirect_valid_o)
    else $error("return redirect late");
  AST_BUSY: assert property (vector_valid_o |-> busy_o && !redirect_valid_o)
    else $error("busy missing while vectoring");
endmodule // evu_core_sva
bind evu_core evu_core_sva u_sva (.*);
`default_nettype wire

// ---- evu_pipe_model.sv ----
// Pipeline model issuing instructions to the vectoring unit
`timescale 1ns/1ns
`default_nettype none
module evu_pipe_model
  import evu_pkg::*;
(
  input wire logic clock_i,
  input wire logic busy_i,
  output logic req_valid_o,
  output evu_req_t req_o,
  output evu_mode_t mode_o,
  output evu_state_t state_o,
  output evu_gate_desc_t gate_o,
  output logic [63:0] table_o
);
  initial begin
    req_valid_o = 1'b0;
    req_o = '0;
    mode_o = EVU_MODE_REAL;
    state_o = '0;
    gate_o = '0;
    table_o = 64'h0;
  end
  // Gate and table held until next issue, the unit reads them late
  task automatic op(input evu_req_t r, input evu_mode_t m, input evu_state_t s,
    input evu_gate_desc_t g, input logic [63:0] t);
    int k;
    repeat ($urandom % 3) @(posedge clock_i);
    @(posedge clock_i);
    req_valid_o <= 1'b1;
    req_o <= r;
    mode_o <= m;
    state_o <= s;
    gate_o <= g;
    table_o <= t;
    @(posedge clock_i);
    req_valid_o <= 1'b0;
    req_o <= evu_req_t'(~r);
    repeat (2) @(posedge clock_i);
    for (k = 0; k < 40 && busy_i; k++) @(posedge clock_i);
    @(posedge clock_i);
  endtask
endmodule // evu_pipe_model
`default_nettype wire

// ---- exception_vectoring_unit_bench.sv ----
// Testbench of the exception vectoring unit
`timescale 1ns/1ns
`default_nettype none
`include "evu_defines.svh"
module exception_vectoring_unit_bench;
  import evu_pkg::*;
  typedef struct {
    logic [7:0] v; logic [63:0] n; logic [63:0] by; logic ifl; logic c64; logic z;
    logic [1:0] k; logic [15:0] cs; logic [63:0] ip; evu_state_t st;
    logic [63:0] pv [6];
  } evu_note_t;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic req_valid_i, busy_o, table_index_valid_o, push_valid_o, redirect_valid_o;
  logic code64_o, task_save_o, vector_valid_o, act;
  logic [7:0] table_index_o, vector_o;
  logic [63:0] rm_table_entry_i, t, np;
  logic [255:0] w;
  evu_req_t req_i, r;
  evu_mode_t mode_i;
  evu_state_t cur_state_i, redirect_state_o, task_saved_o, s, last;
  evu_gate_desc_t gate_i, g;
  evu_push_t push_o;
  evu_note_t q[$];
  evu_note_t c;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  int i, seed;
  always #5 clock_i = ~clock_i;
  evu_core dut (.*);
  evu_pipe_model pipe (.clock_i(clock_i), .busy_i(busy_o), .req_valid_o(req_valid_i),
    .req_o(req_i), .mode_o(mode_i), .state_o(cur_state_i), .gate_o(gate_i),
    .table_o(rm_table_entry_i));
  task automatic chk64(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_st(input evu_state_t got, input evu_state_t exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic rnd(input evu_ins_t k);
    w = {8{$urandom}};
    s = evu_state_t'(w[$bits(evu_state_t)-1:0]);
    w = {8{$urandom}};
    g = evu_gate_desc_t'(w[$bits(evu_gate_desc_t)-1:0]);
    g.gate = EVU_GATE_INTR;
    w = {8{$urandom}};
    r = evu_req_t'(w[$bits(evu_req_t)-1:0]);
    r.kind = k;
    t = {$urandom, $urandom};
  endtask
  task automatic fire(input evu_mode_t m, input logic raise);
    evu_note_t e;
    logic ch;
    int o;
    ch = g.dpl != s.current_privilege_level;
    e.v = r.kind == EVU_INS_SOFT_INT ? r.vector : r.kind == EVU_INS_OVF_TRAP ? `EVU_VEC_OVERFLOW :
      r.kind == EVU_INS_BREAK ? `EVU_VEC_BREAKPOINT : r.kind == EVU_INS_RANGE ? `EVU_VEC_RANGE :
      r.kind == EVU_INS_FPU ? `EVU_VEC_FP_ERROR : `EVU_VEC_SIMD_FP;
    e.by = m == EVU_MODE_REAL ? `EVU_RM_PUSH_BYTES :
      m == EVU_MODE_PROT ? `EVU_PUSH_BYTES_LEG : `EVU_PUSH_BYTES_64;
    e.k = r.kind == EVU_INS_INTERRUPT_RETURN_INSTRUCTION ? 2'h2 : (g.gate == EVU_GATE_TASK && m != EVU_MODE_REAL) ? 2'h1 : 2'h0;
    e.n = e.k != 2'h0 ? 64'h0 : 64'(3 + int'(r.has_error) +
      ((m == EVU_MODE_LONG || (m == EVU_MODE_PROT && ch)) ? 2 : 0));
    e.ifl = g.gate == EVU_GATE_TRAP && m != EVU_MODE_REAL ? s.flags[`EVU_FLAG_INT_ENABLE] : 1'b0;
    e.c64 = m == EVU_MODE_LONG && !g.smm;
    e.z = m == EVU_MODE_LONG && ch;
    e.cs = m == EVU_MODE_REAL ? t[31:16] : g.cs;
    e.ip = m == EVU_MODE_REAL ? {48'h0, t[15:0]} : g.ip;
    // Push order: stack pair in long mode or when switched, then flags, code selector, pointer, error
    o = (m == EVU_MODE_LONG || (m == EVU_MODE_PROT && ch)) ? 2 : 0;
    e.pv[0] = {48'h0, s.ss};
    e.pv[1] = s.sp;
    e.pv[o] = {32'h0, s.flags};
    e.pv[o + 1] = {48'h0, s.cs};
    e.pv[o + 2] = s.ip;
    e.pv[o + 3] = {32'h0, r.error_code};
    e.st = e.k == 2'h2 ? last : s;
    if (raise) q.push_back(e);
    if (raise && e.k != 2'h2) last = s;
    pipe.op(r, m, s, g, t);
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc > 3000) begin
      failures++;
      end_of_test();
    end
    if (reset_n_i) begin
      if (vector_valid_o || (redirect_valid_o && !act)) begin
        if (q.size() == 0) chk64(64'h1, 64'h0);
        else c = q.pop_front();
        act = 1'b1;
        np = 64'h0;
      end
      if (vector_valid_o) chk64(64'(vector_o), 64'(c.v));
      if (table_index_valid_o) chk64(64'(table_index_o), 64'(c.v));
      if (push_valid_o) chk64(push_o.value, c.pv[np]);
      if (push_valid_o) np++;
      if (push_valid_o) chk64(push_o.bytes, c.by);
      if (task_save_o) chk_st(task_saved_o, c.st);
      if (redirect_valid_o) begin
        act = 1'b0;
        if (c.k == 2'h2) begin
          chk64(64'({redirect_state_o.flags, redirect_state_o.cs}),
            64'({c.st.flags, c.st.cs}));
          chk64(redirect_state_o.ip, c.st.ip);
        end else begin
          chk64(np, c.n);
          if (c.k == 2'h1) chk64(redirect_state_o.ip, c.ip);
          if (c.z) chk64(64'(redirect_state_o.ss), 64'(`EVU_NULL_SELECTOR));
        end
        if (c.k == 2'h0) begin
          chk64(64'(redirect_state_o.flags[`EVU_FLAG_INT_ENABLE]), 64'(c.ifl));
          chk64(64'(code64_o), 64'(c.c64));
          chk64(64'(redirect_state_o.cs), 64'(c.cs));
          chk64(redirect_state_o.ip, c.ip);
        end
      end
    end
  end
  // ****************
  // Scenarios
  // ****************
  initial begin
    act = 1'b0;
    seed = int'($urandom(32'h0BE2));
    repeat (12) @(posedge clock_i);
    reset_n_i <= 1'b1;
    for (i = 0; i < 6; i++) begin
      rnd(EVU_INS_SOFT_INT);
      if (i < 2) r.vector = 8'h04 + 8'(i);
      fire(EVU_MODE_REAL, 1'b1);
    end
    rnd(EVU_INS_INTERRUPT_RETURN_INSTRUCTION);
    fire(EVU_MODE_REAL, 1'b1);
    for (i = 0; i < 6; i++) begin
      rnd(EVU_INS_BREAK);
      g.gate = evu_gate_t'(2'(i % 3));
      s.current_privilege_level = 2'h3;
      g.dpl = i < 3 ? 2'h3 : 2'h0;
      fire(EVU_MODE_PROT, 1'b1);
      rnd(EVU_INS_INTERRUPT_RETURN_INSTRUCTION);
      if (i % 3 == 2) fire(EVU_MODE_PROT, 1'b1);
    end
    for (i = 0; i < 4; i++) begin
      rnd(EVU_INS_SIMD);
      r.fp_cond = 6'h01 << i;
      g.gate = evu_gate_t'(2'(i % 2));
      g.dpl = 2'(i / 2);
      s.current_privilege_level = 2'h0;
      fire(EVU_MODE_LONG, 1'b1);
    end
    for (i = 0; i < 2; i++) begin
      rnd(EVU_INS_OVF_TRAP);
      s.flags[`EVU_FLAG_OVERFLOW] = i[0];
      fire(EVU_MODE_PROT, i[0]);
    end
    for (i = 0; i < 4; i++) begin
      rnd(EVU_INS_RANGE);
      r.lower = 32'h0000000A;
      r.upper = 32'h00000014;
      r.operand = 32'h00000009 + 32'(i + i / 2 * 9);
      fire(EVU_MODE_PROT, i == 0 || i == 3);
    end
    for (i = 0; i < 8; i++) begin
      rnd(i < 7 ? EVU_INS_FPU : EVU_INS_SIMD);
      r.fp_cond = i < 6 ? 6'h01 << i : 6'h00;
      s.flags[`EVU_FLAG_OVERFLOW] = 1'b1;
      fire(EVU_MODE_PROT, i < 6);
    end
    repeat (4) @(posedge clock_i);
    chk64(64'(q.size()), 64'h0);
    end_of_test();
  end
endmodule // exception_vectoring_unit_bench
`default_nettype wire
